// ---- hdl/line_capture.sv ----
// Snapshot register for the sixteen port lines, loaded on each trigger.
// Assumes the trigger strobe is a one-cycle pulse in the board clock domain.
`timescale 1ns/1ps
module line_capture (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Capture request and line levels
   input wire logic capture,
   input wire logic [lvds_io_pkg::NUM_LINES-1:0] lines,
   // Held snapshot
   output logic [lvds_io_pkg::NUM_LINES-1:0] captured
);
   import lvds_io_pkg::*;

   typedef struct packed {
      logic [NUM_LINES-1:0] snap;
   } cap_state_t;

   cap_state_t state_r;
   cap_state_t state_nxt;

   always_comb begin
      state_nxt = state_r;
      if (capture) begin
         state_nxt.snap = lines;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         state_r <= '0;
      end else begin
         state_r <= state_nxt;
      end
   end

   assign captured = state_r.snap;

endmodule : line_capture

// ---- hdl/lvds_io_group_config.sv ----
// Front-panel 16-line port: legacy fixed map or per-group extended modes,
// busy and veto forming, and register access to its configuration.
// Assumes all inputs are synchronous to clk and a synchronous reset.
`timescale 1ns/1ps
// Contract
// - Per-group direction and mode apply only when extended enable is set.
// - One direction bit per group of four: zero input, one output.
// - Legacy map: trigger requests on 0,2,4,6; full, ready, run on 8,9,11.
// - Each group's mode comes from its own 4-bit field.
// - All sixteen lines are captured on every trigger.
// - Register mode input groups read their live line levels.
// - Register mode output groups drive the last written levels.
// - Trigger mode outputs gate on even lines; odd lines reserved.
// - Handshake input: lowest line external busy, next line veto, low active.
// - Handshake output: busy, veto, gate, run, all active low.
// - Busy is almost-full or enabled external busy; also to trigger-out.
// - Almost-full rises when occupancy reaches the 12-bit level.
// - Enabled low veto blocks the common trigger; veto out repeats it.
// - Mode register bit picks the low gate source.
// - Low run output is always the inverse of run state.
// - Legacy status groups are outputs: busy, ready, gate, run, high.
// - Legacy busy is inverse of low busy; level zero gives memory full.
// - Legacy ready is high while a complete event is stored.
module lvds_io_group_config (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Register access
   input wire logic [lvds_io_pkg::ADDR_W-1:0] regAddr,
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [lvds_io_pkg::DATA_W-1:0] regWdata,
   output logic [lvds_io_pkg::DATA_W-1:0] regRdata,
   output logic regRdValid,
   // Port lines
   input wire logic [lvds_io_pkg::NUM_LINES-1:0] portIn,
   output logic [lvds_io_pkg::NUM_LINES-1:0] portOut,
   output logic [lvds_io_pkg::NUM_LINES-1:0] portOe,
   // Board status
   input wire logic [lvds_io_pkg::NUM_GROUPS-1:0] groupTrigReq,
   input wire logic memFull,
   input wire logic eventAvailable,
   input wire logic runState,
   input wire logic acqGate,
   input wire logic gpoTrigger,
   input wire logic [lvds_io_pkg::LEVEL_W-1:0] bufferOccupancy,
   // Trigger path
   input wire logic triggerPulse,
   input wire logic commonTrigReq,
   output logic commonTrigOut,
   output logic triggerOutBusy,
   output logic almostFull,
   output logic [lvds_io_pkg::NUM_LINES-1:0] capturedLines
);
   import lvds_io_pkg::*;

   typedef struct packed {
      logic [NUM_LINES-1:0] lineLevels;
      logic extEnable;
      logic [NUM_GROUPS-1:0] groupDir;
      logic [LEVEL_W-1:0] afLevel;
      logic [16:0] modeSel;
      logic holdAllow;
      logic inhibitAllow;
      logic [NUM_LINES-1:0] pinOut;
      logic [NUM_LINES-1:0] pinOe;
      logic almostFull;
      logic busy;
      logic commonTrig;
      logic [DATA_W-1:0] rdata;
      logic rdValid;
   } port_state_t;

   port_state_t state_r;
   port_state_t state_nxt;

   // Mode field of one group
   function automatic logic [GROUP_W-1:0] groupMode(
      input logic [16:0] sel,
      input int g
   );
      groupMode = sel[g*GROUP_W +: GROUP_W];
   endfunction : groupMode

   // True when a group acts as a handshake input
   function automatic logic isHandshakeIn(
      input logic ext,
      input logic dir,
      input logic [GROUP_W-1:0] mode
   );
      isHandshakeIn = ext && !dir && (mode == MODE_LOW_HANDSHAKE);
   endfunction : isHandshakeIn

   // Equality of a bus address to a register offset
   function automatic logic hit(
      input logic [ADDR_W-1:0] a,
      input logic [15:0] off
   );
      hit = (a == off);
   endfunction : hit

   logic extHoldActive;
   logic extInhibitActive;
   logic afNow;
   logic busyNow;
   logic gateLowSrc;
   logic [NUM_LINES-1:0] liveView;
   logic [GROUP_W-1:0] grpOut;
   logic [GROUP_W-1:0] grpOe;
   logic [GROUP_W-1:0] mode;

   // External busy and veto gathered from every handshake input group
   always_comb begin
      extHoldActive = 1'b0;
      extInhibitActive = 1'b0;
      for (int g = 0; g < NUM_GROUPS; g++) begin
         if (isHandshakeIn(state_r.extEnable, state_r.groupDir[g],
                           groupMode(state_r.modeSel, g))) begin
            if (!portIn[g*GROUP_W + HOLD_LINE]) begin
               extHoldActive = 1'b1;
            end
            if (!portIn[g*GROUP_W + INHIBIT_LINE]) begin
               extInhibitActive = 1'b1;
            end
         end
      end
   end

   // Busy forming. A zero level would otherwise hold busy forever, so it
   // falls back to the memory-full flag, keeping the old full behaviour.
   always_comb begin
      if (state_r.afLevel == RST_ALMOST_FULL) begin
         afNow = memFull;
      end else begin
         afNow = (bufferOccupancy >= state_r.afLevel);
      end
      busyNow = afNow || (extHoldActive && state_r.holdAllow);
      if (state_r.modeSel[GATE_SRC_BIT]) begin
         gateLowSrc = gpoTrigger;
      end else begin
         gateLowSrc = acqGate;
      end
   end

   // Value returned by the line level register
   always_comb begin
      liveView = state_r.lineLevels;
      for (int g = 0; g < NUM_GROUPS; g++) begin
         if (state_r.extEnable && !state_r.groupDir[g] &&
             groupMode(state_r.modeSel, g) == MODE_REGISTER) begin
            liveView[g*GROUP_W +: GROUP_W] = portIn[g*GROUP_W +: GROUP_W];
         end
      end
   end

   always_comb begin
      state_nxt = state_r;
      grpOut = '0;
      grpOe = '0;
      mode = '0;

      // Register writes
      if (regWrite) begin
         if (hit(regAddr, OFF_LINE_LEVELS)) begin
            state_nxt.lineLevels = regWdata[NUM_LINES-1:0];
         end
         if (hit(regAddr, OFF_DIR_CTRL)) begin
            state_nxt.extEnable = regWdata[DIR_EXT_EN_BIT];
            state_nxt.groupDir = regWdata[DIR_GROUP_LSB +: NUM_GROUPS];
         end
         if (hit(regAddr, OFF_ALMOST_FULL)) begin
            state_nxt.afLevel = regWdata[LEVEL_W-1:0];
         end
         if (hit(regAddr, OFF_MODE_SEL)) begin
            state_nxt.modeSel = regWdata[16:0];
         end
         if (hit(regAddr, OFF_ACQ_CTRL)) begin
            state_nxt.holdAllow = regWdata[HOLD_ALLOW_BIT];
            state_nxt.inhibitAllow = regWdata[INHIBIT_ALLOW_BIT];
         end
      end

      // Register reads: one cycle latency, unmapped offsets read zero
      state_nxt.rdValid = regRead;
      state_nxt.rdata = '0;
      if (regRead) begin
         if (hit(regAddr, OFF_LINE_LEVELS)) begin
            state_nxt.rdata[NUM_LINES-1:0] = liveView;
         end
         if (hit(regAddr, OFF_DIR_CTRL)) begin
            state_nxt.rdata[DIR_EXT_EN_BIT] = state_r.extEnable;
            state_nxt.rdata[DIR_GROUP_LSB +: NUM_GROUPS] = state_r.groupDir;
         end
         if (hit(regAddr, OFF_ALMOST_FULL)) begin
            state_nxt.rdata[LEVEL_W-1:0] = state_r.afLevel;
         end
         if (hit(regAddr, OFF_MODE_SEL)) begin
            state_nxt.rdata[16:0] = state_r.modeSel;
         end
         if (hit(regAddr, OFF_ACQ_CTRL)) begin
            state_nxt.rdata[HOLD_ALLOW_BIT] = state_r.holdAllow;
            state_nxt.rdata[INHIBIT_ALLOW_BIT] = state_r.inhibitAllow;
         end
      end

      // Busy, almost-full and veto-gated common trigger
      state_nxt.almostFull = afNow;
      state_nxt.busy = busyNow;
      state_nxt.commonTrig = commonTrigReq &&
                             !(state_r.inhibitAllow && extInhibitActive);

      // Line drive
      state_nxt.pinOut = '0;
      state_nxt.pinOe = '0;
      if (!state_r.extEnable) begin
         // Fixed legacy map; unlisted lines are left undriven
         for (int g = 0; g < NUM_GROUPS; g++) begin
            state_nxt.pinOut[2*g] = groupTrigReq[g];
            state_nxt.pinOe[2*g] = 1'b1;
         end
         state_nxt.pinOut[LEG_MEM_FULL_LINE] = memFull;
         state_nxt.pinOe[LEG_MEM_FULL_LINE] = 1'b1;
         state_nxt.pinOut[LEG_DATA_READY_LINE] = eventAvailable;
         state_nxt.pinOe[LEG_DATA_READY_LINE] = 1'b1;
         state_nxt.pinOut[LEG_RUN_LINE] = runState;
         state_nxt.pinOe[LEG_RUN_LINE] = 1'b1;
      end else begin
         for (int g = 0; g < NUM_GROUPS; g++) begin
            mode = groupMode(state_r.modeSel, g);
            grpOut = '0;
            grpOe = state_r.groupDir[g] ? 4'hF : 4'h0;
            case (mode)
               MODE_REGISTER: begin
                  grpOut = state_r.lineLevels[g*GROUP_W +: GROUP_W];
               end
               MODE_TRIGGER: begin
                  // Odd lines stay low as reserved outputs
                  grpOut = {1'b0, acqGate, 1'b0, acqGate};
               end
               MODE_LOW_HANDSHAKE: begin
                  grpOut = {!runState, !gateLowSrc,
                            !extInhibitActive, !busyNow};
               end
               MODE_LEGACY: begin
                  // Status groups drive all four lines whatever their direction bit says
                  grpOe = 4'hF;
                  grpOut = {runState, acqGate,
                            eventAvailable, busyNow};
               end
               default: begin
                  grpOut = '0;
               end
            endcase
            state_nxt.pinOut[g*GROUP_W +: GROUP_W] = grpOut & grpOe;
            state_nxt.pinOe[g*GROUP_W +: GROUP_W] = grpOe;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         state_r.lineLevels <= RST_LINE_LEVELS;
         state_r.extEnable <= RST_EXT_EN;
         state_r.groupDir <= RST_DIR;
         state_r.afLevel <= RST_ALMOST_FULL;
         state_r.modeSel <= RST_MODE_SEL;
         state_r.holdAllow <= RST_HOLD_ALLOW;
         state_r.inhibitAllow <= RST_INHIBIT_ALLOW;
         state_r.pinOut <= '0;
         state_r.pinOe <= '0;
         state_r.almostFull <= 1'b0;
         state_r.busy <= 1'b0;
         state_r.commonTrig <= 1'b0;
         state_r.rdata <= '0;
         state_r.rdValid <= 1'b0;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Snapshot of the wire levels, independent of any mode setting
   line_capture u_capture (
      .clk(clk),
      .reset(reset),
      .capture(triggerPulse),
      .lines(portIn),
      .captured(capturedLines)
   );

   assign regRdata = state_r.rdata;
   assign regRdValid = state_r.rdValid;
   assign portOut = state_r.pinOut;
   assign portOe = state_r.pinOe;
   assign commonTrigOut = state_r.commonTrig;
   assign triggerOutBusy = state_r.busy;
   assign almostFull = state_r.almostFull;

endmodule : lvds_io_group_config

// ---- shared/lvds_io_pkg.sv ----
// Shared constants for the front-panel differential I/O port block.
// Assumes a single board clock and a synchronous, active-high reset.
package lvds_io_pkg;

   // Port geometry
   localparam int NUM_LINES = 16;
   localparam int NUM_GROUPS = 4;
   localparam int GROUP_W = 4;
   localparam int LEVEL_W = 12;
   localparam int ADDR_W = 16;
   localparam int DATA_W = 32;

   // Register offsets
   localparam logic [15:0] OFF_LINE_LEVELS = 16'h8118;
   localparam logic [15:0] OFF_DIR_CTRL = 16'h811C;
   localparam logic [15:0] OFF_ALMOST_FULL = 16'h816C;
   localparam logic [15:0] OFF_MODE_SEL = 16'h81A0;
   localparam logic [15:0] OFF_ACQ_CTRL = 16'h8100;

   // Field positions
   localparam int DIR_GROUP_LSB = 2;
   localparam int DIR_EXT_EN_BIT = 8;
   localparam int HOLD_ALLOW_BIT = 8;
   localparam int INHIBIT_ALLOW_BIT = 9;
   localparam int GATE_SRC_BIT = 16;
   localparam int HOLD_LINE = 0;
   localparam int INHIBIT_LINE = 1;

   // Group mode codes
   localparam logic [3:0] MODE_REGISTER = 4'h0;
   localparam logic [3:0] MODE_TRIGGER = 4'h1;
   localparam logic [3:0] MODE_LOW_HANDSHAKE = 4'h2;
   localparam logic [3:0] MODE_LEGACY = 4'h3;

   // Reset values
   localparam logic [15:0] RST_LINE_LEVELS = 16'h0000;
   localparam logic [3:0] RST_DIR = 4'h0;
   localparam logic RST_EXT_EN = 1'b0;
   localparam logic [11:0] RST_ALMOST_FULL = 12'h000;
   localparam logic [16:0] RST_MODE_SEL = 17'h0_0000;
   localparam logic RST_HOLD_ALLOW = 1'b0;
   localparam logic RST_INHIBIT_ALLOW = 1'b0;

   // Fixed legacy line positions
   localparam int LEG_MEM_FULL_LINE = 8;
   localparam int LEG_DATA_READY_LINE = 9;
   localparam int LEG_RUN_LINE = 11;

endpackage : lvds_io_pkg

// ---- verif/far_side_model.sv ----
// Far-side logic on the sixteen port lines and the resolved wire level.
// Assumes the bench gives the far side's drive pattern and enables.
`timescale 1ns/1ps
module far_side_model (
   // Clock
   input wire logic clk,
   // Device side
   input wire logic [lvds_io_pkg::NUM_LINES-1:0] portOut,
   input wire logic [lvds_io_pkg::NUM_LINES-1:0] portOe,
   // Far side drive
   input wire logic [lvds_io_pkg::NUM_LINES-1:0] farVal,
   input wire logic [lvds_io_pkg::NUM_LINES-1:0] farEn,
   // Resolved wire
   output logic [lvds_io_pkg::NUM_LINES-1:0] portIn
);
   import lvds_io_pkg::*;
   logic [NUM_LINES-1:0] floatPat = 16'h5A5A;
   // Floating lines keep changing so a stale level never reads as valid
   always @(posedge clk) begin
      floatPat <= ~floatPat;
   end
   // Device drive wins, then far-side drive; undriven lines take the float pattern
   assign portIn = (portOe & portOut) | (~portOe & farEn & farVal) | (~portOe & ~farEn & floatPat);
endmodule : far_side_model

// ---- verif/lvds_io_group_config_checker.sv ----
// Pin-level assertions for the front-panel port block.
// Assumes it is bound to lvds_io_group_config; shadows two config fields.
`timescale 1ns/1ps
module lvds_io_group_config_checker (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Register access
   input wire logic [lvds_io_pkg::ADDR_W-1:0] regAddr,
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [lvds_io_pkg::DATA_W-1:0] regWdata,
   input wire logic regRdValid,
   // Port and status
   input wire logic [lvds_io_pkg::NUM_LINES-1:0] portIn,
   input wire logic [lvds_io_pkg::NUM_LINES-1:0] portOut,
   input wire logic [lvds_io_pkg::NUM_LINES-1:0] portOe,
   input wire logic [lvds_io_pkg::NUM_GROUPS-1:0] groupTrigReq,
   input wire logic memFull,
   input wire logic eventAvailable,
   input wire logic runState,
   input wire logic [lvds_io_pkg::LEVEL_W-1:0] bufferOccupancy,
   // Trigger path
   input wire logic triggerPulse,
   input wire logic commonTrigReq,
   input wire logic commonTrigOut,
   input wire logic triggerOutBusy,
   input wire logic almostFull,
   input wire logic [lvds_io_pkg::NUM_LINES-1:0] capturedLines
);
   import lvds_io_pkg::*;
   logic extSh;
   logic [LEVEL_W-1:0] levelSh;
   logic afCause;
   // Shadows let pin checks know the map and level without seeing the body
   always_ff @(posedge clk) begin
      if (reset) begin
         extSh <= RST_EXT_EN;
         levelSh <= RST_ALMOST_FULL;
      end else if (regWrite && regAddr == OFF_DIR_CTRL) begin
         extSh <= regWdata[DIR_EXT_EN_BIT];
      end else if (regWrite && regAddr == OFF_ALMOST_FULL) begin
         levelSh <= regWdata[LEVEL_W-1:0];
      end
   end
   assign afCause = (levelSh == '0) ? memFull : (bufferOccupancy >= levelSh);
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   sequence s_snap;
      ##1 capturedLines == $past(portIn);
   endsequence
   sequence s_legacy;
      {portOut[11], portOut[9], portOut[8]} == $past({runState, eventAvailable, memFull})
         && {portOut[6], portOut[4], portOut[2], portOut[0]} == $past(groupTrigReq);
   endsequence
   property p_cap; triggerPulse |-> s_snap; endproperty
   property p_hold; !triggerPulse |=> $stable(capturedLines); endproperty
   property p_rdv; regRead |=> regRdValid; endproperty
   property p_oe; (portOut & ~portOe) == '0; endproperty
   property p_busy; almostFull |-> triggerOutBusy; endproperty
   property p_ctrig; !commonTrigReq |=> !commonTrigOut; endproperty
   property p_af; 1'b1 |=> almostFull == $past(afCause); endproperty
   property p_legoe; !extSh |=> portOe == 16'h0B55; endproperty
   property p_legout; !extSh |=> s_legacy; endproperty
   a_cap: assert property (p_cap) else $error("snapshot differs from lines");
   a_hold: assert property (p_hold) else $error("snapshot moved");
   a_rdv: assert property (p_rdv) else $error("read answer missing");
   a_oe: assert property (p_oe) else $error("undriven line not low");
   a_busy: assert property (p_busy) else $error("busy missing");
   a_ctrig: assert property (p_ctrig) else $error("trigger from nothing");
   a_af: assert property (p_af) else $error("almost-full wrong");
   a_legoe: assert property (p_legoe) else $error("legacy enables wrong");
   a_legout: assert property (p_legout) else $error("legacy levels wrong");
endmodule : lvds_io_group_config_checker

bind lvds_io_group_config lvds_io_group_config_checker chk (.clk, .reset, .regAddr,
   .regWrite, .regRead, .regWdata, .regRdValid, .portIn, .portOut, .portOe, .groupTrigReq,
   .memFull, .eventAvailable, .runState, .bufferOccupancy, .triggerPulse, .commonTrigReq,
   .commonTrigOut, .triggerOutBusy, .almostFull, .capturedLines);

// ---- verif/test_lvds_io_group_config.sv ----
// Self-checking bench for the front-panel port block.
// Assumes the far-side model resolves every line and the checker is bound.
`timescale 1ns/1ps
module test_lvds_io_group_config;
   import lvds_io_pkg::*;
   logic clk, reset, regWrite, regRead, regRdValid, memFull, eventAvailable, runState;
   logic acqGate, gpoTrigger, triggerPulse, commonTrigReq, commonTrigOut, triggerOutBusy;
   logic almostFull;
   logic [15:0] regAddr, portIn, portOut, portOe, capturedLines, farVal, farEn;
   logic [31:0] regWdata, regRdata;
   logic [3:0] groupTrigReq;
   logic [11:0] bufferOccupancy;
   int failCount = 0;
   int numChecks = 0;
   int cycles = 0;

   lvds_io_group_config uut (.clk, .reset, .regAddr, .regWrite, .regRead, .regWdata,
      .regRdata, .regRdValid, .portIn, .portOut, .portOe, .groupTrigReq, .memFull,
      .eventAvailable, .runState, .acqGate, .gpoTrigger, .bufferOccupancy, .triggerPulse,
      .commonTrigReq, .commonTrigOut, .triggerOutBusy, .almostFull, .capturedLines);
   far_side_model far (.clk, .portOut, .portOe, .farVal, .farEn, .portIn);

   task automatic reportAndStop();
      $display("checks %0d mismatches %0d", numChecks, failCount);
      if (failCount == 0 && numChecks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : reportAndStop
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      numChecks++;
      if (got !== exp) begin
         failCount++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic chkp(input logic [15:0] got, input logic [15:0] exp);
      chk({16'h0000, got}, {16'h0000, exp});
   endtask : chkp
   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      regAddr = a;
      regWdata = d;
      regWrite = 1'b1;
      @(negedge clk);
      regWrite = 1'b0;
      @(negedge clk);
   endtask : wr
   task automatic rdChk(input logic [15:0] a, input logic [31:0] exp);
      int n;
      regAddr = a;
      regRead = 1'b1;
      @(negedge clk);
      regRead = 1'b0;
      for (n = 0; n < 4 && regRdValid !== 1'b1; n++) begin
         @(negedge clk);
      end
      chk(regRdata, exp);
   endtask : rdChk
   task automatic tRegs();
      rdChk(OFF_DIR_CTRL, 32'h0000_0000);
      rdChk(OFF_MODE_SEL, 32'h0000_0000);
      wr(OFF_MODE_SEL, 32'hFFFF_FFFF);
      rdChk(OFF_MODE_SEL, 32'h0001_FFFF);
      wr(OFF_ALMOST_FULL, 32'hFFFF_FFFF);
      rdChk(OFF_ALMOST_FULL, 32'h0000_0FFF);
      wr(16'h8120, 32'hFFFF_FFFF);
      rdChk(16'h8120, 32'h0000_0000);
      wr(OFF_ALMOST_FULL, 32'h0000_0000);
   endtask : tRegs
   task automatic tLegacy();
      // Extended config is written but stays dormant without the enable
      wr(OFF_MODE_SEL, 32'h0000_2222);
      wr(OFF_DIR_CTRL, 32'h0000_003C);
      groupTrigReq = 4'hA;
      memFull = 1'b1;
      runState = 1'b1;
      repeat (3) @(negedge clk);
      chkp(portOe, 16'h0B55);
      chkp(portOut, 16'h0944);
      {groupTrigReq, memFull, eventAvailable, runState} = 7'h2A;
      repeat (3) @(negedge clk);
      chkp(portOut, 16'h0211);
      wr(OFF_MODE_SEL, 32'h0000_0000);
   endtask : tLegacy
   task automatic tRegMode();
      farEn = 16'hFFF0;
      farVal = 16'h1230;
      wr(OFF_DIR_CTRL, 32'h0000_0104);
      wr(OFF_LINE_LEVELS, 32'h0000_BEEF);
      repeat (3) @(negedge clk);
      chkp(portOe, 16'h000F);
      chkp(portOut, 16'h000F);
      rdChk(OFF_LINE_LEVELS, 32'h0000_123F);
      farEn = 16'h0FFF;
      wr(OFF_DIR_CTRL, 32'h0000_0120);
      repeat (3) @(negedge clk);
      chkp(portOut, 16'hB000);
   endtask : tRegMode
   task automatic tTrigMode();
      farEn = 16'hF0FF;
      wr(OFF_DIR_CTRL, 32'h0000_0110);
      wr(OFF_MODE_SEL, 32'h0000_1100);
      acqGate = 1'b1;
      repeat (3) @(negedge clk);
      chkp(portOut & 16'hFF00, 16'h0500);
      chkp(portOe & 16'hF000, 16'h0000);
      acqGate = 1'b0;
      repeat (3) @(negedge clk);
      chkp(portOut & 16'hFF00, 16'h0000);
      // An undefined mode code on an output group must drive low, not float
      wr(OFF_DIR_CTRL, 32'h0000_0130);
      wr(OFF_MODE_SEL, 32'h0000_F100);
      acqGate = 1'b1;
      repeat (3) @(negedge clk);
      chkp(portOut & 16'hFF00, 16'h0500);
      chkp(portOe & 16'hF000, 16'hF000);
   endtask : tTrigMode
   task automatic tHandshake();
      farEn = 16'hF00F;
      farVal = 16'hFFFE;
      {acqGate, runState, eventAvailable, commonTrigReq} = 4'hF;
      wr(OFF_MODE_SEL, 32'h0000_0322);
      wr(OFF_DIR_CTRL, 32'h0000_0118);
      wr(OFF_ACQ_CTRL, 32'h0000_0100);
      repeat (3) @(negedge clk);
      chkp(portOut, 16'h0F20);
      chkp(16'(triggerOutBusy), 16'h0001);
      farVal = 16'hFFFC;
      wr(OFF_ACQ_CTRL, 32'h0000_0200);
      repeat (3) @(negedge clk);
      chkp(portOut, 16'h0E10);
      chkp(16'({commonTrigOut, triggerOutBusy}), 16'h0000);
      farVal = 16'hFFFF;
      repeat (3) @(negedge clk);
      chkp(16'({commonTrigOut, triggerOutBusy}), 16'h0002);
      {acqGate, gpoTrigger, runState} = 3'b010;
      wr(OFF_MODE_SEL, 32'h0001_0322);
      repeat (3) @(negedge clk);
      chkp(portOut, 16'h02B0);
   endtask : tHandshake
   task automatic afCase(input logic [11:0] lv, input logic [11:0] oc, input logic mf);
      wr(OFF_ALMOST_FULL, {20'h0_0000, lv});
      bufferOccupancy = oc;
      memFull = mf;
      repeat (3) @(negedge clk);
   endtask : afCase
   task automatic tAlmost();
      wr(OFF_ACQ_CTRL, 32'h0000_0000);
      afCase(12'h003, 12'h002, 1'b1);
      chkp(16'({almostFull, triggerOutBusy, portOut[8]}), 16'h0000);
      afCase(12'h003, 12'h003, 1'b0);
      chkp(16'({almostFull, triggerOutBusy, portOut[8]}), 16'h0007);
      afCase(12'h000, 12'h000, 1'b1);
      chkp(16'({almostFull, triggerOutBusy, portOut[8]}), 16'h0007);
   endtask : tAlmost
   task automatic tCapture();
      {groupTrigReq, memFull, eventAvailable, runState} = 7'h00;
      farEn = 16'hF4AA;
      farVal = 16'hA5A5;
      wr(OFF_DIR_CTRL, 32'h0000_0000);
      repeat (3) @(negedge clk);
      triggerPulse = 1'b1;
      @(negedge clk);
      triggerPulse = 1'b0;
      farVal = 16'h0000;
      @(negedge clk);
      chkp(capturedLines, 16'hA4A0);
   endtask : tCapture
   task automatic tReset();
      // Mid-run reset must drop every setting back to the legacy map
      reset = 1'b1;
      repeat (2) @(negedge clk);
      reset = 1'b0;
      @(negedge clk);
      chkp(portOe, 16'h0B55);
      chkp(capturedLines, 16'h0000);
      rdChk(OFF_MODE_SEL, 32'h0000_0000);
   endtask : tReset

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         failCount++;
         reportAndStop();
      end
   end
   initial begin
      reset = 1'b1;
      {regWrite, regRead, memFull, eventAvailable, runState, acqGate} = '0;
      {gpoTrigger, triggerPulse, commonTrigReq, groupTrigReq, bufferOccupancy} = '0;
      {regAddr, regWdata} = '0;
      farVal = 16'hFFFF;
      farEn = 16'h0000;
      repeat (8) @(negedge clk);
      reset = 1'b0;
      @(negedge clk);
      tRegs();
      tLegacy();
      tRegMode();
      tTrigMode();
      tHandshake();
      tAlmost();
      tCapture();
      tReset();
      reportAndStop();
   end
endmodule : test_lvds_io_group_config
